// ---- alu_pkg.sv ----
// Purpose: Shared constants and encodings for the sixteen-bit CPU arithmetic datapath.
// Assumes: One 250 MHz clock; registers reached over classic Wishbone with 32-bit data.
// Notes:   Functional notes follow; tags mark the logic in the datapath module.
`default_nettype none

package alu_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] CORE_CONTROL_OFS = 8'h00;
    localparam logic [7:0] STATUS_WORD_OFS  = 8'h04;

    // Core control field positions and the fixed reserved bit.
    localparam int         PRIO_MSB_BIT     = 3;
    localparam int         RESERVED_ONE_BIT = 2;
    localparam logic       PRIO_MSB_RESET   = 1'b0;

    // Status word field positions.
    localparam int STAT_C_BIT   = 0;
    localparam int STAT_Z_BIT   = 1;
    localparam int STAT_OV_BIT  = 2;
    localparam int STAT_N_BIT   = 3;
    localparam int STAT_IPL_LSB = 5;
    localparam int STAT_DC_BIT  = 8;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Datapath widths and derived divider iteration count.
    localparam int DATA_W     = 16;
    localparam int DIV_CYCLES = DATA_W;

    // Operation codes from the instruction decoder.
    typedef enum logic [3:0] {
        OP_ADD  = 4'h0,
        OP_ADDC = 4'h1,
        OP_SUB  = 4'h2,
        OP_SUBB = 4'h3,
        OP_AND  = 4'h4,
        OP_IOR  = 4'h5,
        OP_XOR  = 4'h6,
        OP_ASR  = 4'h7,
        OP_SL   = 4'h8,
        OP_LSR  = 4'h9,
        OP_MUL  = 4'hA,
        OP_DIV  = 4'hB
    } alu_op_e;

    // Multiplier signedness and width modes.
    typedef enum logic [2:0] {
        MUL_SS   = 3'h0,
        MUL_UU   = 3'h1,
        MUL_SU   = 3'h2,
        MUL_US   = 3'h3,
        MUL_SLIT = 3'h4,
        MUL_ULIT = 3'h5,
        MUL_BB   = 3'h6
    } mul_mode_e;

    // Divider sequence, Gray coded along idle, run, quotient, remainder.
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_WQ   = 2'b11,
        DIV_WR   = 2'b10
    } div_state_e;

endpackage

`default_nettype wire

// ---- cpu_alu_mul_div_shift.sv ----
// Purpose: CPU arithmetic datapath: ALU with flags, multiplier, divider, barrel shifter.
// Assumes: Decoder drives requests on ref_clk; sys_rst is synchronous active high.
// Notes:   Single-cycle ops answer one cycle after acceptance; division takes 18 cycles.
`default_nettype none

module cpu_alu_mul_div_shift (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Wishbone slave for the core control and status word registers.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt controller raises the priority extension bit.
    input  wire logic        prio_msb_set,
    output logic      [3:0]  priority_level,
    // Operation request from the decoder.
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic [2:0]  mul_mode,
    input  wire logic        byte_mode,
    input  wire logic        div_signed,
    input  wire logic        div_long,
    input  wire logic        src_is_mem,
    input  wire logic        dst_is_mem,
    input  wire logic [15:0] opnd_a,
    input  wire logic [15:0] opnd_b,
    input  wire logic [15:0] opnd_hi,
    input  wire logic [3:0]  shift_amt,
    output logic             op_ready,
    output logic             busy,
    // Single-cycle results.
    output logic             res_valid,
    output logic      [15:0] res_data,
    output logic      [15:0] res_hi,
    output logic             res_to_mem,
    output logic             op_error,
    output logic      [15:0] status_word,
    // Divider write-back to the working register file.
    output logic             wr_en,
    output logic      [3:0]  wr_addr,
    output logic      [15:0] wr_data
);

    logic               prio_msb_q;
    logic [15:0]        status_q;
    logic               ack_q;
    logic [31:0]        rdata_q;
    alu_pkg::div_state_e div_state_q;
    logic [4:0]         div_cnt_q;
    logic [16:0]        rem_q;
    logic [15:0]        sh_q;
    logic [15:0]        dvs_q;
    logic               neg_q_q;
    logic               neg_r_q;
    logic               wr_en_q;
    logic [3:0]         wr_addr_q;
    logic [15:0]        wr_data_q;
    logic               res_valid_q;
    logic [15:0]        res_q;
    logic [15:0]        res_hi_q;
    logic               res_to_mem_q;
    logic               op_error_q;

    logic               bus_req;
    logic               wr_core;
    logic               wr_stat;
    logic               take;
    logic               is_shift;
    logic               refuse;
    logic               flag_upd;
    logic               carry_in;
    logic [15:0]        b_eff;
    logic [16:0]        sum17;
    logic [8:0]         sum9;
    logic [4:0]         sum5;
    logic [15:0]        sh_src;
    logic [31:0]        rsh;
    logic [31:0]        lsh;
    logic [16:0]        mul_a;
    logic [16:0]        mul_b;
    logic [33:0]        product;
    logic [15:0]        alu_res;
    logic               alu_c;
    logic               alu_dc;
    logic               alu_ov;
    logic               upd_c;
    logic               upd_ov_dc;
    logic [31:0]        dvd_full;
    logic [31:0]        dvd_mag;
    logic [15:0]        dvs_mag;
    logic [16:0]        trial;
    logic               trial_ok;
    // Bus decode; a request is answered once, in the cycle after it appears.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_core = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == alu_pkg::CORE_CONTROL_OFS);
    assign wr_stat = bus_req && wb_we_i && (wb_adr_i == alu_pkg::STATUS_WORD_OFS);
    // Ack and read data come from flops; unmapped addresses ack with zero data.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i == alu_pkg::CORE_CONTROL_OFS) begin
                    rdata_q[alu_pkg::PRIO_MSB_BIT]     <= prio_msb_q;
                    rdata_q[alu_pkg::RESERVED_ONE_BIT] <= 1'b1;
                end else if (wb_adr_i == alu_pkg::STATUS_WORD_OFS) begin
                    rdata_q[15:0] <= status_q;
                end
            end
        end
    end
    // Extension bit: hardware sets it, software writing zero clears it, and a set
    // in the same cycle as a clear wins so a raised level is never lost.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prio_msb_q <= alu_pkg::PRIO_MSB_RESET;
        end else if (prio_msb_set) begin
            prio_msb_q <= 1'b1;
        end else if (wr_core && !wb_dat_i[alu_pkg::PRIO_MSB_BIT]) begin
            prio_msb_q <= 1'b0;
        end
    end
    // Level above seven exactly when the extension bit is one.
    assign priority_level = {prio_msb_q, status_q[alu_pkg::STAT_IPL_LSB +: 3]};
    // Request acceptance and the multi-bit shift addressing check.
    assign take     = op_valid && op_ready;
    assign is_shift = (op_code == alu_pkg::OP_ASR) || (op_code == alu_pkg::OP_SL) ||
                      (op_code == alu_pkg::OP_LSR);
    assign refuse   = take && is_shift && (shift_amt > 4'h1) && (src_is_mem || dst_is_mem);
    assign flag_upd = take && !refuse && (op_code != alu_pkg::OP_MUL) &&
                      (op_code != alu_pkg::OP_DIV);
    // Adder in two's complement; subtraction adds the inverted operand plus carry.
    always_comb begin
        b_eff    = opnd_b;
        carry_in = 1'b0;
        case (op_code)
            alu_pkg::OP_ADDC: carry_in = status_q[alu_pkg::STAT_C_BIT];
            alu_pkg::OP_SUB: begin
                b_eff    = ~opnd_b;
                carry_in = 1'b1;
            end
            alu_pkg::OP_SUBB: begin
                b_eff    = ~opnd_b;
                carry_in = status_q[alu_pkg::STAT_C_BIT];
            end
            default: carry_in = 1'b0;
        endcase
    end
    assign sum17 = {1'b0, opnd_a} + {1'b0, b_eff} + {16'h0000, carry_in};
    assign sum9  = {1'b0, opnd_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, carry_in};
    assign sum5  = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
    // Barrel shifter: a doubled word carries the last bit shifted out below the result on right shifts, above it on left.
    always_comb begin
        if (op_code == alu_pkg::OP_ASR) begin
            sh_src = byte_mode ? {{8{opnd_a[7]}}, opnd_a[7:0]} : opnd_a;
        end else begin
            sh_src = byte_mode ? {8'h00, opnd_a[7:0]} : opnd_a;
        end
    end

    assign rsh = (op_code == alu_pkg::OP_ASR) ? 32'($signed({sh_src, 16'h0000}) >>> shift_amt)
                                              : ({sh_src, 16'h0000} >> shift_amt);
    assign lsh = {16'h0000, opnd_a} << shift_amt;
    // Operands widened to 17 bits per mode so one signed multiplier covers all.
    always_comb begin
        mul_a = {opnd_a[15], opnd_a};
        mul_b = {opnd_b[15], opnd_b};
        case (mul_mode)
            alu_pkg::MUL_UU: begin
                mul_a = {1'b0, opnd_a};
                mul_b = {1'b0, opnd_b};
            end
            alu_pkg::MUL_SU:   mul_b = {1'b0, opnd_b};
            alu_pkg::MUL_US:   mul_a = {1'b0, opnd_a};
            alu_pkg::MUL_SLIT: mul_b = {12'h000, opnd_b[4:0]};
            alu_pkg::MUL_ULIT: begin
                mul_a = {1'b0, opnd_a};
                mul_b = {12'h000, opnd_b[4:0]};
            end
            alu_pkg::MUL_BB: begin
                mul_a = {9'h000, opnd_a[7:0]};
                mul_b = {9'h000, opnd_b[7:0]};
            end
            default: mul_b = {opnd_b[15], opnd_b};
        endcase
    end

    assign product = 34'($signed(mul_a) * $signed(mul_b));
    // Result and carry selection; byte ops keep the upper byte of operand a.
    always_comb begin
        alu_res   = sum17[15:0];
        alu_c     = byte_mode ? sum9[8] : sum17[16];
        alu_dc    = byte_mode ? sum5[4] : sum9[8];
        alu_ov    = byte_mode ? ((opnd_a[7] == b_eff[7]) && (sum9[7] != opnd_a[7]))
                              : ((opnd_a[15] == b_eff[15]) && (sum17[15] != opnd_a[15]));
        upd_c     = 1'b1;
        upd_ov_dc = 1'b1;
        case (op_code)
            alu_pkg::OP_AND: alu_res = opnd_a & opnd_b;
            alu_pkg::OP_IOR: alu_res = opnd_a | opnd_b;
            alu_pkg::OP_XOR: alu_res = opnd_a ^ opnd_b;
            alu_pkg::OP_ASR, alu_pkg::OP_LSR: begin
                alu_res = rsh[31:16];
                alu_c   = rsh[15];
            end
            alu_pkg::OP_SL: begin
                alu_res = lsh[15:0];
                alu_c   = byte_mode ? lsh[8] : lsh[16];
            end
            default: alu_res = sum17[15:0];
        endcase
        if (op_code == alu_pkg::OP_AND || op_code == alu_pkg::OP_IOR ||
            op_code == alu_pkg::OP_XOR) begin
            upd_c     = 1'b0;
            upd_ov_dc = 1'b0;
        end else if (is_shift) begin
            upd_c     = (shift_amt != 4'h0);
            upd_ov_dc = 1'b0;
        end
        if (byte_mode) begin
            alu_res = {opnd_a[15:8], alu_res[7:0]};
        end
    end
    // Registered single-cycle results; destination choice passes through.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_valid_q  <= 1'b0;
            res_q        <= 16'h0000;
            res_hi_q     <= 16'h0000;
            res_to_mem_q <= 1'b0;
            op_error_q   <= 1'b0;
        end else begin
            res_valid_q <= take && !refuse && (op_code != alu_pkg::OP_DIV);
            op_error_q  <= refuse;
            if (take && !refuse && (op_code != alu_pkg::OP_DIV)) begin
                res_to_mem_q <= dst_is_mem;
                if (op_code == alu_pkg::OP_MUL) begin
                    res_q    <= product[15:0];
                    res_hi_q <= product[31:16];
                end else begin
                    res_q    <= alu_res;
                    res_hi_q <= 16'h0000;
                end
            end
        end
    end
    // Status word: flag updates from the unit win over a software write.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_q <= alu_pkg::STATUS_RESET;
        end else begin
            if (wr_stat && wb_sel_i[0]) begin
                status_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_stat && wb_sel_i[1]) begin
                status_q[alu_pkg::STAT_DC_BIT] <= wb_dat_i[alu_pkg::STAT_DC_BIT];
            end
            if (flag_upd) begin
                status_q[alu_pkg::STAT_Z_BIT] <= byte_mode ? (alu_res[7:0] == 8'h00)
                                                           : (alu_res == 16'h0000);
                status_q[alu_pkg::STAT_N_BIT] <= byte_mode ? alu_res[7] : alu_res[15];
                if (upd_c) begin
                    status_q[alu_pkg::STAT_C_BIT] <= alu_c;
                end
                if (upd_ov_dc) begin
                    status_q[alu_pkg::STAT_OV_BIT] <= alu_ov;
                    status_q[alu_pkg::STAT_DC_BIT] <= alu_dc;
                end
            end
        end
    end
    // Divider operand preparation: long dividend is the odd:even register pair.
    assign dvd_full = div_long ? {opnd_hi, opnd_a}
                    : (div_signed ? {{16{opnd_a[15]}}, opnd_a} : {16'h0000, opnd_a});
    assign dvd_mag  = (div_signed && dvd_full[31]) ? 32'(-dvd_full) : dvd_full;
    assign dvs_mag  = (div_signed && opnd_b[15]) ? 16'(-opnd_b) : opnd_b;
    assign trial    = {rem_q[15:0], sh_q[15]};
    assign trial_ok = trial >= {1'b0, dvs_q};
    // Restoring divider on magnitudes, one quotient bit per cycle, then two
    // write-back cycles; a quotient wider than 16 bits is not detected and gives a wrong value.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_state_q <= alu_pkg::DIV_IDLE;
            div_cnt_q   <= 5'h00;
            rem_q       <= 17'h00000;
            sh_q        <= 16'h0000;
            dvs_q       <= 16'h0000;
            neg_q_q     <= 1'b0;
            neg_r_q     <= 1'b0;
            wr_en_q     <= 1'b0;
            wr_addr_q   <= 4'h0;
            wr_data_q   <= 16'h0000;
        end else begin
            wr_en_q <= 1'b0;
            case (div_state_q)
                alu_pkg::DIV_IDLE: begin
                    if (take && op_code == alu_pkg::OP_DIV) begin
                        rem_q       <= {1'b0, dvd_mag[31:16]};
                        sh_q        <= dvd_mag[15:0];
                        dvs_q       <= dvs_mag;
                        neg_q_q     <= div_signed && (dvd_full[31] ^ opnd_b[15]);
                        neg_r_q     <= div_signed && dvd_full[31];
                        div_cnt_q   <= 5'h00;
                        div_state_q <= alu_pkg::DIV_RUN;
                    end
                end
                alu_pkg::DIV_RUN: begin
                    rem_q     <= trial_ok ? 17'(trial - {1'b0, dvs_q}) : trial;
                    sh_q      <= {sh_q[14:0], trial_ok};
                    div_cnt_q <= 5'(div_cnt_q + 5'h01);
                    if (div_cnt_q == 5'(alu_pkg::DIV_CYCLES - 1)) begin
                        div_state_q <= alu_pkg::DIV_WQ;
                    end
                end
                alu_pkg::DIV_WQ: begin
                    wr_en_q     <= 1'b1;
                    wr_addr_q   <= 4'h0;
                    wr_data_q   <= neg_q_q ? 16'(-sh_q) : sh_q;
                    div_state_q <= alu_pkg::DIV_WR;
                end
                alu_pkg::DIV_WR: begin
                    wr_en_q     <= 1'b1;
                    wr_addr_q   <= 4'h1;
                    wr_data_q   <= neg_r_q ? 16'(-rem_q[15:0]) : rem_q[15:0];
                    div_state_q <= alu_pkg::DIV_IDLE;
                end
                default: div_state_q <= alu_pkg::DIV_IDLE;
            endcase
        end
    end
    // Busy covers iteration and both write-back cycles.
    assign busy        = (div_state_q != alu_pkg::DIV_IDLE) || wr_en_q;
    assign op_ready    = !busy;
    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdata_q;
    assign res_valid   = res_valid_q;
    assign res_data    = res_q;
    assign res_hi      = res_hi_q;
    assign res_to_mem  = res_to_mem_q;
    assign op_error    = op_error_q;
    assign status_word = status_q;
    assign wr_en       = wr_en_q;
    assign wr_addr     = wr_addr_q;
    assign wr_data     = wr_data_q;
    // Checks on the datapath's own outputs.
    sequence s_div_start;
        take && (op_code == alu_pkg::OP_DIV);
    endsequence
    sequence s_div_writes;
        (wr_en && wr_addr == 4'h0 && busy) ##1 (wr_en && wr_addr == 4'h1 && busy);
    endsequence

    a_div_write_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_div_start |-> ##18 s_div_writes) else $error("divide write-back timing wrong");
    a_div_busy_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_div_start |=> busy [*8]) else $error("busy dropped during divide");
    a_prio_sw_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_core && !wb_dat_i[3] && !prio_msb_set) |=> !priority_level[3])
        else $error("priority extension not cleared");
    a_prio_no_sw_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!priority_level[3] && !prio_msb_set) |=> !priority_level[3])
        else $error("priority extension set without hardware");
    a_core_read_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_req && !wb_we_i && wb_adr_i == 8'h00) |=>
        (wb_ack_o && wb_dat_o[2] && wb_dat_o[15:4] == 12'h000 && wb_dat_o[1:0] == 2'b00))
        else $error("core control read bits wrong");
    a_bus_ack_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
    a_add_carry_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (flag_upd && op_code == alu_pkg::OP_ADD && !byte_mode) |=>
        (status_word[0] == ((32'($past(opnd_a)) + 32'($past(opnd_b))) > 32'h0000_FFFF)))
        else $error("add carry flag wrong");
    a_neg_flag_msb: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (flag_upd && !byte_mode) |=> (status_word[3] == res_data[15]))
        else $error("negative flag does not match result");
    a_shift_refused: assert property (@(posedge ref_clk) disable iff (sys_rst)
        refuse |=> (op_error && !res_valid)) else $error("memory multi-bit shift accepted");
    a_asr_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take && !refuse && op_code == alu_pkg::OP_ASR && !byte_mode) |=>
        (res_data == 16'($signed($past(opnd_a)) >>> $past(shift_amt))))
        else $error("arithmetic right shift wrong");
    a_mul_unsigned: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take && op_code == alu_pkg::OP_MUL && mul_mode == alu_pkg::MUL_UU) |=>
        ({res_hi, res_data} == $past(opnd_a) * $past(opnd_b)))
        else $error("unsigned product wrong");

endmodule

`default_nettype wire

// ---- work_regs_model.sv ----
// Purpose: Working register file that takes the divider write-back.
// Assumes: A write lands on the rising edge while wr_en is high.
// Notes:   Behavioural; the bench reads regs by hierarchy.
`default_nettype none
module work_regs (
    input  wire logic        ref_clk,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] regs [16];
    // Writes land on the edge, so a slip of one cycle shows in the readback.
    always @(posedge ref_clk) begin
        if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end
endmodule
`default_nettype wire

// ---- cpu_alu_mul_div_shift_tb_top.sv ----
// Purpose: Self-checking bench for the arithmetic datapath.
// Assumes: Single-cycle ops answer one cycle after acceptance; registers over Wishbone.
// Notes:   Random add and subtract operands come from a fixed seed.
`default_nettype none
module cpu_alu_mul_div_shift_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, sys_rst = 1'h1, cyc = 1'h0, we = 1'h0, pset = 1'h0;
    logic opv = 1'h0, bm = 1'h0, dsg = 1'h0, dl = 1'h0, sm = 1'h0, dm = 1'h0, s;
    logic [7:0] adr = 8'h00;
    logic [31:0] di = 32'h0, dout, rd;
    logic [3:0] oc = 4'h0, sa = 4'h0, pl, wa;
    logic [2:0] mm = 3'h0;
    logic [15:0] a = 16'h0, b = 16'h0, h = 16'h0, rdat, rhi, sw, wd, x, y, e;
    logic ack, rdy, bsy, rv, rtm, oerr, wen;
    int n_mismatch = 0, samples_checked = 0, seed = 22644, k;
    logic [31:0] mx [7] = '{32'h1, 32'hFFFE0001, 32'hFFFF0001, 32'hFFFF0001,
                            32'hFFFFFFE1, 32'h001EFFE1, 32'h0000FE01};
    logic [15:0] se [3] = '{16'hFFFF, 16'h8000, 16'h0001};
    cpu_alu_mul_div_shift dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di),
        .wb_dat_o(dout), .wb_ack_o(ack), .prio_msb_set(pset), .priority_level(pl),
        .op_valid(opv), .op_code(oc), .mul_mode(mm), .byte_mode(bm), .div_signed(dsg),
        .div_long(dl), .src_is_mem(sm), .dst_is_mem(dm), .opnd_a(a), .opnd_b(b),
        .opnd_hi(h), .shift_amt(sa), .op_ready(rdy), .busy(bsy), .res_valid(rv),
        .res_data(rdat), .res_hi(rhi), .res_to_mem(rtm), .op_error(oerr),
        .status_word(sw), .wr_en(wen), .wr_addr(wa), .wr_data(wd));
    work_regs u_regs (.ref_clk(ref_clk), .wr_en(wen), .wr_addr(wa), .wr_data(wd));
    // Free-running 250 MHz clock.
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Expected C, Z, OV, N and DC; subtraction adds the inverse plus one.
    function automatic logic [15:0] fl(input logic sb, input logic [15:0] p, q);
        logic [16:0] t;
        logic [8:0]  l;
        logic [15:0] v;
        v = sb ? ~q : q;
        t = p + v + sb;
        l = p[7:0] + v[7:0] + sb;
        fl = {7'h0, l[8], 4'h0, t[15], (p[15] == v[15]) && (t[15] != p[15]),
              t[15:0] == 16'h0, t[16]};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then idle one cycle.
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        cyc <= 1'h1;
        we <= w;
        adr <= ad;
        di <= d;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'h1 && k < 20);
        if (ack !== 1'h1) n_mismatch++;
        rd = dout;
        cyc <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic op(input logic [3:0] c, input logic [15:0] p, q);
        opv <= 1'h1;
        oc <= c;
        a <= p;
        b <= q;
        @(posedge ref_clk);
        opv <= 1'h0;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (rdy !== 1'h1 && k < 40);
        if (rdy !== 1'h1) n_mismatch++;
    endtask
    task automatic dv(input logic l, g, input logic [15:0] p, q, r);
        dl <= l;
        dsg <= g;
        h <= 16'h0001;
        op(4'hB, p, q);
        chk(k, 32'h14);
        chk(u_regs.regs[0], r);
    endtask
    task automatic tally_and_finish;
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // The run is under two hundred cycles; this cuts a hang short.
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        wb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h4);
        wb(1'h1, 8'h04, 32'hE0);
        pset <= 1'h1;
        @(posedge ref_clk);
        pset <= 1'h0;
        wb(1'h0, 8'h00, 32'h0);
        chk({rd[27:0], pl}, 32'hCF);
        wb(1'h1, 8'h00, 32'hFFF7);
        wb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, 8'h00, 32'h0);
        chk({rd[27:0], pl}, 32'h47);
        wb(1'h1, 8'h00, 32'h8);
        wb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h4);
        $display("register test done");
        for (int i = 0; i < 24; i++) begin
            x = (i < 2) ? 16'h7FFF : 16'($random(seed));
            y = (i < 2) ? 16'h8001 - 16'(i) : 16'($random(seed));
            s = i[0];
            e = s ? x - y : x + y;
            op({2'h0, s, 1'h0}, x, y);
            chk(rdat, e);
            chk(rv, 1'h1);
            chk(sw & 16'h010F, fl(s, x, y));
        end
        bm <= 1'h1;
        dm <= 1'h1;
        op(4'h0, 16'h12FF, 16'h0001);
        chk({rdat, rtm}, 17'h02401);
        bm <= 1'h0;
        sm <= 1'h1;
        sa <= 4'hF;
        op(4'h7, 16'h8000, 16'h0);
        chk(oerr, 1'h1);
        chk(rv, 1'h0);
        sm <= 1'h0;
        dm <= 1'h0;
        for (int j = 0; j < 3; j++) begin
            op(4'h7 + 4'(j), j == 1 ? 16'h0001 : 16'h8000, 16'h0);
            chk(rdat, se[j]);
        end
        for (int m = 0; m < 7; m++) begin
            mm <= 3'(m);
            op(4'hA, 16'hFFFF, 16'hFFFF);
            chk({rhi, rdat}, mx[m]);
        end
        dv(1'h1, 1'h0, 16'h0005, 16'h0010, 16'h1000);
        chk(u_regs.regs[1], 16'h0005);
        dv(1'h0, 1'h1, 16'hFFF9, 16'h0002, 16'hFFFD);
        chk(u_regs.regs[1], 16'hFFFF);
        $display("datapath test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
